// ### hw/lcf_pkg.sv
package lcf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LCF_ADDR_LED1_MASK = 8'h07;
	localparam logic [7:0] LCF_ADDR_LED1_TORCH = 8'h08;
	localparam logic [7:0] LCF_ADDR_LED2_FLASH = 8'h09;
	localparam logic [7:0] LCF_ADDR_LED2_MASK = 8'h0a;
	localparam logic [7:0] LCF_ADDR_LED2_TORCH = 8'h0b;
	localparam logic [7:0] LCF_ADDR_FAULT = 8'h0c;

	// ----------------------------------------------------------------
	// Reset values and code widths
	// ----------------------------------------------------------------
	localparam logic [7:0] LCF_RST_FLASH_MASK = 8'h28;
	localparam logic [7:0] LCF_RST_TORCH = 8'h04;
	localparam logic [7:0] LCF_RST_FAULT = 8'h00;
	localparam int LCF_WIDE_W = 6;
	localparam int LCF_TORCH_W = 5;
	localparam logic [5:0] LCF_WIDE_SAT = 6'h3c;
	localparam logic [4:0] LCF_TORCH_SAT = 5'h10;

	// ----------------------------------------------------------------
	// Fault register bit positions
	// ----------------------------------------------------------------
	localparam int LCF_BIT_OVP = 7;
	localparam int LCF_BIT_SC = 6;
	localparam int LCF_BIT_OT = 5;
	localparam int LCF_BIT_TO = 4;
	localparam int LCF_BIT_MASK = 3;
	localparam int LCF_BIT_VBLO = 2;
	localparam int LCF_BIT_IL = 1;
	localparam int LCF_BIT_IDC = 0;

	// ----------------------------------------------------------------
	// Serial interface
	// ----------------------------------------------------------------
	localparam logic [3:0] LCF_BYTE_BITS = 4'h8;
	localparam logic [6:0] LCF_DEV_ADDR_DEFAULT = 7'h30;
	localparam int LCF_SYNC_W = 9;

	typedef enum logic [3:0] {
		LCF_IDLE = 4'h0,
		LCF_ADDR = 4'h1,
		LCF_ADDR_ACK = 4'h2,
		LCF_REG = 4'h3,
		LCF_REG_ACK = 4'h4,
		LCF_WDATA = 4'h5,
		LCF_WDATA_ACK = 4'h6,
		LCF_RDATA = 4'h7,
		LCF_RDATA_ACK = 4'h8
	} lcf_state_t;

endpackage

// ### hw/lcf_sync.sv
`timescale 1ns/1ps
module lcf_sync #(
	parameter int WIDTH = 1,
	// Lines that idle high wake at one, so reset release shows no false edge.
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	import lcf_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} lcf_sync_t;

	lcf_sync_t state_reg;
	lcf_sync_t state_next;

	always_comb begin
		state_next.meta = i_async;
		state_next.held = state_reg.meta;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= '{meta: RESET, held: RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sync = state_reg.held;
endmodule

// ### hw/lcf_clamp.sv
`timescale 1ns/1ps
module lcf_clamp #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] SAT = '1,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_code,
	output logic [WIDTH-1:0] o_code
);
	import lcf_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] code;
	} lcf_clamp_t;

	lcf_clamp_t state_reg;
	lcf_clamp_t state_next;

	// Codes past the top step give no extra current, so they collapse onto it.
	always_comb begin
		state_next.code = (i_code >= SAT) ? SAT : i_code;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg.code <= RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_code = state_reg.code;
endmodule

// ### hw/lcf_regs.sv
// Behaviour
// - Hold six-bit LED1 transmit-mask current code.
// - Hold five-bit LED1 torch current code.
// - Hold six-bit LED2 flash current code.
// - Hold six-bit LED2 transmit-mask current code.
// - Hold five-bit LED2 torch current code.
// - Six-bit codes saturate at 0x3C.
// - Five-bit codes saturate at 0x10.
// - Six-bit fields reset to 0x28.
// - Torch fields reset to 0x04.
// - Bit 7 flags over-voltage.
// - Bit 6 flags LED short circuit.
// - Bit 5 flags over-temperature.
// - Bit 4 flags flash timeout.
// - Bit 3 flags masking during last flash.
// - Bit 2 shows supply below low-battery threshold.
// - Bit 1 flags inductor peak limit.
// - Bit 0 flags input dc limit reached.
`timescale 1ns/1ps
module lcf_regs #(
	parameter logic [6:0] DEV_ADDR = lcf_pkg::LCF_DEV_ADDR_DEFAULT
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_overvoltage,
	input wire logic i_short_circuit,
	input wire logic i_overtemp,
	input wire logic i_inductor_limit,
	input wire logic i_input_dc_limit,
	input wire logic i_low_battery,
	input wire logic i_transmit_mask_input,
	input wire logic i_flash_active,
	input wire logic i_flash_timeout,
	input wire logic i_input_dc_limit_enable,
	input wire logic i_low_battery_enable,
	output logic [lcf_pkg::LCF_WIDE_W-1:0] o_led1_mask_current_code,
	output logic [lcf_pkg::LCF_TORCH_W-1:0] o_led1_torch_current_code,
	output logic [lcf_pkg::LCF_WIDE_W-1:0] o_led2_flash_current_code,
	output logic [lcf_pkg::LCF_WIDE_W-1:0] o_led2_mask_current_code,
	output logic [lcf_pkg::LCF_TORCH_W-1:0] o_led2_torch_current_code,
	output logic [7:0] o_fault_information
);
	import lcf_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		lcf_state_t state;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic nack;
		logic scl_prev;
		logic sda_prev;
		logic flash_prev;
		logic sda_out;
		logic sda_oe;
		logic [7:0] led1_mask;
		logic [7:0] led1_torch;
		logic [7:0] led2_flash;
		logic [7:0] led2_mask;
		logic [7:0] led2_torch;
		logic [7:0] faults;
	} lcf_regs_t;

	localparam lcf_regs_t LCF_REGS_RESET = '{
		state: LCF_IDLE,
		bit_cnt: 4'h0,
		shift: 8'h00,
		ptr: 8'h00,
		rw: 1'b0,
		nack: 1'b0,
		scl_prev: 1'b1,
		sda_prev: 1'b1,
		flash_prev: 1'b0,
		sda_out: 1'b0,
		sda_oe: 1'b0,
		led1_mask: LCF_RST_FLASH_MASK,
		led1_torch: LCF_RST_TORCH,
		led2_flash: LCF_RST_FLASH_MASK,
		led2_mask: LCF_RST_FLASH_MASK,
		led2_torch: LCF_RST_TORCH,
		faults: LCF_RST_FAULT
	};

	lcf_regs_t state_reg;
	lcf_regs_t state_next;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [LCF_SYNC_W-1:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic ovp_s;
	logic sc_s;
	logic ot_s;
	logic il_s;
	logic idc_s;
	logic vblo_s;
	logic transmit_mask_input_s;

	lcf_sync #(
		.WIDTH(LCF_SYNC_W),
		.RESET({2'b11, {(LCF_SYNC_W-2){1'b0}}})
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async({i_scl, i_sda_in, i_overvoltage, i_short_circuit, i_overtemp,
			i_inductor_limit, i_input_dc_limit, i_low_battery, i_transmit_mask_input}),
		.o_sync(pins_sync)
	);

	assign {scl_s, sda_s, ovp_s, sc_s, ot_s, il_s, idc_s, vblo_s, transmit_mask_input_s} = pins_sync;

	// ----------------------------------------------------------------
	// Bus conditions
	// ----------------------------------------------------------------
	logic bus_start;
	logic bus_stop;
	logic scl_rise;
	logic scl_fall;
	logic bit_in;
	logic byte_end;

	assign bus_start = scl_s & state_reg.scl_prev & state_reg.sda_prev & ~sda_s;
	assign bus_stop = scl_s & state_reg.scl_prev & ~state_reg.sda_prev & sda_s;
	assign scl_rise = scl_s & ~state_reg.scl_prev;
	assign scl_fall = ~scl_s & state_reg.scl_prev;
	assign bit_in = scl_rise && (state_reg.bit_cnt != LCF_BYTE_BITS);
	assign byte_end = scl_fall && (state_reg.bit_cnt == LCF_BYTE_BITS);

	// Unmapped addresses read as zero.
	function automatic logic [7:0] lcf_read(input lcf_regs_t s, input logic [7:0] addr);
		logic [7:0] value;
		value = 8'h00;
		case (addr)
			LCF_ADDR_LED1_MASK: value = s.led1_mask;
			LCF_ADDR_LED1_TORCH: value = s.led1_torch;
			LCF_ADDR_LED2_FLASH: value = s.led2_flash;
			LCF_ADDR_LED2_MASK: value = s.led2_mask;
			LCF_ADDR_LED2_TORCH: value = s.led2_torch;
			LCF_ADDR_FAULT: value = s.faults;
			default: value = 8'h00;
		endcase
		return value;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic load_tx;
		logic clear_faults;
		logic flash_begin;
		logic [7:0] tx;
		load_tx = 1'b0;
		clear_faults = 1'b0;
		flash_begin = 1'b0;
		tx = 8'h00;
		state_next = state_reg;
		state_next.scl_prev = scl_s;
		state_next.sda_prev = sda_s;
		state_next.flash_prev = i_flash_active;
		state_next.sda_out = 1'b0;

		if (bus_start) begin
			state_next.state = LCF_ADDR;
			state_next.bit_cnt = 4'h0;
			state_next.sda_oe = 1'b0;
		end else if (bus_stop) begin
			state_next.state = LCF_IDLE;
			state_next.sda_oe = 1'b0;
		end else begin
			case (state_reg.state)
				LCF_IDLE: begin
					state_next.sda_oe = 1'b0;
				end
				LCF_ADDR, LCF_REG, LCF_WDATA: begin
					if (bit_in) begin
						state_next.shift = {state_reg.shift[6:0], sda_s};
						state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
					end else if (byte_end) begin
						state_next.bit_cnt = 4'h0;
						state_next.sda_oe = 1'b1;
						case (state_reg.state)
							LCF_ADDR: begin
								if (state_reg.shift[7:1] == DEV_ADDR) begin
									state_next.rw = state_reg.shift[0];
									state_next.state = LCF_ADDR_ACK;
								end else begin
									state_next.sda_oe = 1'b0;
									state_next.state = LCF_IDLE;
								end
							end
							LCF_REG: begin
								state_next.ptr = state_reg.shift;
								state_next.state = LCF_REG_ACK;
							end
							default: begin
								// The fault register and unmapped addresses take no write.
								case (state_reg.ptr)
									LCF_ADDR_LED1_MASK: state_next.led1_mask = state_reg.shift;
									LCF_ADDR_LED1_TORCH: state_next.led1_torch = state_reg.shift;
									LCF_ADDR_LED2_FLASH: state_next.led2_flash = state_reg.shift;
									LCF_ADDR_LED2_MASK: state_next.led2_mask = state_reg.shift;
									LCF_ADDR_LED2_TORCH: state_next.led2_torch = state_reg.shift;
									default: state_next.ptr = state_reg.ptr;
								endcase
								state_next.ptr = state_reg.ptr + 8'h01;
								state_next.state = LCF_WDATA_ACK;
							end
						endcase
					end
				end
				LCF_ADDR_ACK: begin
					if (scl_fall) begin
						if (state_reg.rw) begin
							load_tx = 1'b1;
						end else begin
							state_next.sda_oe = 1'b0;
							state_next.state = LCF_REG;
						end
					end
				end
				LCF_REG_ACK, LCF_WDATA_ACK: begin
					if (scl_fall) begin
						state_next.sda_oe = 1'b0;
						state_next.state = LCF_WDATA;
					end
				end
				LCF_RDATA: begin
					if (scl_fall) begin
						if (state_reg.bit_cnt == LCF_BYTE_BITS) begin
							state_next.sda_oe = 1'b0;
							state_next.state = LCF_RDATA_ACK;
						end else begin
							state_next.sda_oe = ~state_reg.shift[7];
							state_next.shift = {state_reg.shift[6:0], 1'b0};
							state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
						end
					end
				end
				LCF_RDATA_ACK: begin
					if (scl_rise) begin
						state_next.nack = sda_s;
					end else if (scl_fall) begin
						if (state_reg.nack) begin
							state_next.state = LCF_IDLE;
						end else begin
							load_tx = 1'b1;
						end
					end
				end
				default: begin
					state_next.state = LCF_IDLE;
					state_next.sda_oe = 1'b0;
				end
			endcase
		end

		// The open-drain line is only ever pulled low, so a one is sent by letting go.
		if (load_tx) begin
			tx = lcf_read(state_reg, state_reg.ptr);
			clear_faults = (state_reg.ptr == LCF_ADDR_FAULT);
			state_next.shift = {tx[6:0], 1'b0};
			state_next.sda_oe = ~tx[7];
			state_next.bit_cnt = 4'h1;
			state_next.ptr = state_reg.ptr + 8'h01;
			state_next.state = LCF_RDATA;
		end

		// Latched faults other than the mask flag clear when read; a fault present in that cycle stays set.
		flash_begin = i_flash_active & ~state_reg.flash_prev;
		state_next.faults[LCF_BIT_OVP] = (state_reg.faults[LCF_BIT_OVP] & ~clear_faults) | ovp_s;
		state_next.faults[LCF_BIT_SC] = (state_reg.faults[LCF_BIT_SC] & ~clear_faults) | sc_s;
		state_next.faults[LCF_BIT_OT] = (state_reg.faults[LCF_BIT_OT] & ~clear_faults) | ot_s;
		state_next.faults[LCF_BIT_TO] = (state_reg.faults[LCF_BIT_TO] & ~clear_faults)
			| i_flash_timeout;
		state_next.faults[LCF_BIT_MASK] = (state_reg.faults[LCF_BIT_MASK] & ~flash_begin)
			| (transmit_mask_input_s & i_flash_active);
		state_next.faults[LCF_BIT_VBLO] = vblo_s & i_low_battery_enable;
		state_next.faults[LCF_BIT_IL] = (state_reg.faults[LCF_BIT_IL] & ~clear_faults) | il_s;
		state_next.faults[LCF_BIT_IDC] = ((state_reg.faults[LCF_BIT_IDC] & ~clear_faults) | idc_s)
			& i_input_dc_limit_enable;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= LCF_REGS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Current code outputs
	// ----------------------------------------------------------------
	// Reserved upper bits are stored but never reach the current sources.
	lcf_clamp #(
		.WIDTH(LCF_WIDE_W),
		.SAT(LCF_WIDE_SAT),
		.RESET(LCF_RST_FLASH_MASK[LCF_WIDE_W-1:0])
	) u_led1_mask (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_code(state_reg.led1_mask[LCF_WIDE_W-1:0]),
		.o_code(o_led1_mask_current_code)
	);

	lcf_clamp #(
		.WIDTH(LCF_TORCH_W),
		.SAT(LCF_TORCH_SAT),
		.RESET(LCF_RST_TORCH[LCF_TORCH_W-1:0])
	) u_led1_torch (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_code(state_reg.led1_torch[LCF_TORCH_W-1:0]),
		.o_code(o_led1_torch_current_code)
	);

	lcf_clamp #(
		.WIDTH(LCF_WIDE_W),
		.SAT(LCF_WIDE_SAT),
		.RESET(LCF_RST_FLASH_MASK[LCF_WIDE_W-1:0])
	) u_led2_flash (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_code(state_reg.led2_flash[LCF_WIDE_W-1:0]),
		.o_code(o_led2_flash_current_code)
	);

	lcf_clamp #(
		.WIDTH(LCF_WIDE_W),
		.SAT(LCF_WIDE_SAT),
		.RESET(LCF_RST_FLASH_MASK[LCF_WIDE_W-1:0])
	) u_led2_mask (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_code(state_reg.led2_mask[LCF_WIDE_W-1:0]),
		.o_code(o_led2_mask_current_code)
	);

	lcf_clamp #(
		.WIDTH(LCF_TORCH_W),
		.SAT(LCF_TORCH_SAT),
		.RESET(LCF_RST_TORCH[LCF_TORCH_W-1:0])
	) u_led2_torch (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_code(state_reg.led2_torch[LCF_TORCH_W-1:0]),
		.o_code(o_led2_torch_current_code)
	);

	assign o_sda_out = state_reg.sda_out;
	assign o_sda_oe = state_reg.sda_oe;
	assign o_fault_information = state_reg.faults;
endmodule

// ### testbench/lcf_regs_chk.sv
`timescale 1ns/1ps
module lcf_regs_chk (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_overvoltage,
	input wire logic i_short_circuit,
	input wire logic i_overtemp,
	input wire logic i_inductor_limit,
	input wire logic i_input_dc_limit,
	input wire logic i_low_battery,
	input wire logic i_transmit_mask_input,
	input wire logic i_flash_active,
	input wire logic i_flash_timeout,
	input wire logic i_input_dc_limit_enable,
	input wire logic i_low_battery_enable,
	input wire logic [lcf_pkg::LCF_WIDE_W-1:0] o_led1_mask_current_code,
	input wire logic [lcf_pkg::LCF_TORCH_W-1:0] o_led1_torch_current_code,
	input wire logic [lcf_pkg::LCF_WIDE_W-1:0] o_led2_flash_current_code,
	input wire logic [lcf_pkg::LCF_WIDE_W-1:0] o_led2_mask_current_code,
	input wire logic [lcf_pkg::LCF_TORCH_W-1:0] o_led2_torch_current_code,
	input wire logic [7:0] o_fault_information
);
	import lcf_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Async faults pass a two-flop synchroniser, so a few cycles of slack are allowed.
	sequence s_masked_flash;
		(i_flash_active && i_transmit_mask_input) [*4];
	endsequence
	sequence s_low_batt;
		(i_low_battery && i_low_battery_enable) [*5];
	endsequence
	property p_flag(logic f, logic b);
		f |-> ##[1:6] b;
	endproperty
	a_wide_sat: assert property (o_led1_mask_current_code <= LCF_WIDE_SAT &&
		o_led2_flash_current_code <= LCF_WIDE_SAT && o_led2_mask_current_code <= LCF_WIDE_SAT)
		else $error("six-bit code above saturation");
	a_torch_sat: assert property (o_led1_torch_current_code <= LCF_TORCH_SAT &&
		o_led2_torch_current_code <= LCF_TORCH_SAT) else $error("torch code above saturation");
	a_reset_codes: assert property ($rose(i_nrst) |-> o_led1_mask_current_code == 6'h28 &&
		o_led2_flash_current_code == 6'h28 && o_led2_mask_current_code == 6'h28 &&
		o_led1_torch_current_code == 5'h04 && o_led2_torch_current_code == 5'h04 &&
		o_fault_information == 8'h00) else $error("wrong value after reset");
	a_ovp_latch: assert property (p_flag(i_overvoltage, o_fault_information[7]))
		else $error("over-voltage flag not set");
	a_sc_latch: assert property (p_flag(i_short_circuit, o_fault_information[6]))
		else $error("short-circuit flag not set");
	a_ot_latch: assert property (p_flag(i_overtemp, o_fault_information[5]))
		else $error("over-temperature flag not set");
	a_timeout_latch: assert property (p_flag(i_flash_timeout, o_fault_information[4]))
		else $error("timeout flag not set");
	a_il_latch: assert property (p_flag(i_inductor_limit, o_fault_information[1]))
		else $error("inductor limit flag not set");
	a_idc_latch: assert property (p_flag(i_input_dc_limit && i_input_dc_limit_enable,
		o_fault_information[0])) else $error("dc limit flag not set");
	a_idc_gated: assert property (!i_input_dc_limit_enable [*2] |-> !o_fault_information[0])
		else $error("dc limit flag set while disabled");
	a_mask_flag: assert property (s_masked_flash |-> ##[0:3] o_fault_information[3])
		else $error("mask event flag not set");
	a_lowbat_on: assert property (s_low_batt |-> o_fault_information[2])
		else $error("low battery flag not set");
	// The comparator passes three flops and the enable one, so each is checked on its own.
	a_lowbat_off: assert property ((!i_low_battery) [*4] |-> !o_fault_information[2])
		else $error("low battery flag stuck");
	a_lowbat_gated: assert property (!i_low_battery_enable |=> !o_fault_information[2])
		else $error("low battery flag set while disabled");
endmodule
bind lcf_regs lcf_regs_chk i_lcf_regs_chk (.*);

// ### testbench/lcf_host.sv
`timescale 1ns/1ps
module lcf_host #(
	parameter logic [6:0] DEV = 7'h30
) (
	input wire logic i_clk_sys,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#2;
	endtask
	// SDA moves only four clocks clear of either SCL edge, so the synchroniser sees clean order.
	task automatic bit_io(input logic b, output logic r);
		tick(4);
		o_sda_low = !b;
		tick(4);
		o_scl = 1'b1;
		tick(2);
		r = i_sda;
		tick(2);
		o_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(m_ack, ack);
	endtask
	task automatic start_cond();
		tick(4);
		o_sda_low = 1'b0;
		tick(4);
		o_scl = 1'b1;
		tick(4);
		o_sda_low = 1'b1;
		tick(4);
		o_scl = 1'b0;
	endtask
	task automatic stop_cond();
		tick(4);
		o_sda_low = 1'b1;
		tick(4);
		o_scl = 1'b1;
		tick(4);
		o_sda_low = 1'b0;
	endtask
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic k0, k1, k2;
		start_cond();
		byte_io({dev, 1'b0}, 1'b1, q, k0);
		byte_io(a, 1'b1, q, k1);
		byte_io(d, 1'b1, q, k2);
		stop_cond();
		ok = !(k0 | k1 | k2);
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
		logic [7:0] u;
		logic k;
		start_cond();
		byte_io({DEV, 1'b0}, 1'b1, u, k);
		byte_io(a, 1'b1, u, k);
		start_cond();
		byte_io({DEV, 1'b1}, 1'b1, u, k);
		byte_io(8'hff, 1'b1, q, k);
		stop_cond();
	endtask
endmodule

// ### testbench/test_lcf_regs.sv
`timescale 1ns/1ps
module test_lcf_regs;
	import lcf_pkg::*;
	logic i_clk_sys, i_nrst, i_scl, o_sda_out, o_sda_oe, host_low, ok;
	logic i_overvoltage, i_short_circuit, i_overtemp, i_inductor_limit, i_input_dc_limit;
	logic i_low_battery, i_transmit_mask_input, i_flash_active, i_flash_timeout;
	logic i_input_dc_limit_enable, i_low_battery_enable;
	logic [5:0] o_led1_mask_current_code, o_led2_flash_current_code, o_led2_mask_current_code;
	logic [4:0] o_led1_torch_current_code, o_led2_torch_current_code;
	logic [7:0] o_fault_information, v, acc;
	logic [31:0] r;
	logic [7:0] addrs [5] = '{LCF_ADDR_LED1_MASK, LCF_ADDR_LED1_TORCH, LCF_ADDR_LED2_FLASH,
		LCF_ADDR_LED2_MASK, LCF_ADDR_LED2_TORCH};
	logic [7:0] vals [5] = '{8'h3c, 8'h3b, 8'h10, 8'h0f, 8'hff};
	int flag_bits [6] = '{7, 6, 5, 4, 1, 0};
	int error_cnt = 0;
	int compares = 0;
	integer seed = 32'ha7033d8b;
	wire i_sda_in;
	// The line has a pull-up, so it reads high when nobody pulls it low.
	assign i_sda_in = !(host_low || o_sda_oe);
	lcf_regs i_lcf_regs (.i_clk_sys, .i_nrst, .i_scl, .i_sda_in, .o_sda_out, .o_sda_oe,
		.i_overvoltage, .i_short_circuit, .i_overtemp, .i_inductor_limit, .i_input_dc_limit,
		.i_low_battery, .i_transmit_mask_input, .i_flash_active, .i_flash_timeout,
		.i_input_dc_limit_enable, .i_low_battery_enable, .o_led1_mask_current_code,
		.o_led1_torch_current_code, .o_led2_flash_current_code, .o_led2_mask_current_code,
		.o_led2_torch_current_code, .o_fault_information);
	lcf_host #(.DEV(LCF_DEV_ADDR_DEFAULT)) i_lcf_host (.i_clk_sys, .i_sda(i_sda_in),
		.o_scl(i_scl), .o_sda_low(host_low));
	function automatic logic [7:0] exp_code(input int k, input logic [7:0] w);
		if (k == 1 || k == 4) return (w[4:0] >= LCF_TORCH_SAT) ? 8'h10 : {3'h0, w[4:0]};
		return (w[5:0] >= LCF_WIDE_SAT) ? 8'h3c : {2'h0, w[5:0]};
	endfunction
	function automatic logic [7:0] port_code(input int k);
		logic [7:0] c [5];
		c = '{{2'h0, o_led1_mask_current_code}, {3'h0, o_led1_torch_current_code},
			{2'h0, o_led2_flash_current_code}, {2'h0, o_led2_mask_current_code},
			{3'h0, o_led2_torch_current_code}};
		return c[k];
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
		logic [7:0] q;
		i_lcf_host.read_reg(a, q);
		check(name, q, e);
	endtask
	task automatic set_faults(input logic [7:0] f);
		{i_overvoltage, i_short_circuit, i_overtemp, i_flash_timeout} = f[7:4];
		{i_low_battery, i_inductor_limit, i_input_dc_limit} = f[2:0];
	endtask
	task automatic pulse_faults(input logic [7:0] f);
		set_faults(f);
		i_lcf_host.tick(3);
		set_faults(8'h00);
		i_lcf_host.tick(6);
	endtask
	task automatic give_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		#1_600_000;
		error_cnt++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		i_nrst = 1'b0;
		set_faults(8'h00);
		{i_transmit_mask_input, i_flash_active} = 2'b00;
		{i_input_dc_limit_enable, i_low_battery_enable} = 2'b00;
		repeat (8) @(posedge i_clk_sys);
		#2 i_nrst = 1'b1;
		i_lcf_host.tick(4);
		for (int k = 0; k < 5; k++) rd(addrs[k], (k == 1 || k == 4) ? LCF_RST_TORCH :
			LCF_RST_FLASH_MASK, "reset value");
		rd(LCF_ADDR_FAULT, 8'h00, "fault reset value");
		$display("test reset values done");
		for (int k = 0; k < 5; k++) for (int j = 0; j < 7; j++) begin
			v = (j > 4) ? 8'($random(seed)) : vals[j];
			i_lcf_host.write_reg(LCF_DEV_ADDR_DEFAULT, addrs[k], v, ok);
			check("write ack", {7'h0, ok}, 8'h01);
			rd(addrs[k], v, "readback");
			check("current code", port_code(k), exp_code(k, v));
		end
		$display("test current codes done");
		i_nrst = 1'b0;
		i_lcf_host.tick(2);
		i_nrst = 1'b1;
		i_lcf_host.tick(4);
		for (int k = 0; k < 5; k++) check("code after reset", port_code(k), exp_code(k,
			(k == 1 || k == 4) ? LCF_RST_TORCH : LCF_RST_FLASH_MASK));
		rd(addrs[4], LCF_RST_TORCH, "register after reset");
		$display("test reset in run done");
		i_lcf_host.write_reg(LCF_DEV_ADDR_DEFAULT, LCF_ADDR_FAULT, 8'hff, ok);
		rd(LCF_ADDR_FAULT, 8'h00, "fault after write");
		i_lcf_host.write_reg(LCF_DEV_ADDR_DEFAULT, addrs[0], 8'h2a, ok);
		i_lcf_host.write_reg(LCF_DEV_ADDR_DEFAULT ^ 7'h01, addrs[0], 8'h11, ok);
		check("foreign address ack", {7'h0, ok}, 8'h00);
		rd(addrs[0], 8'h2a, "after foreign write");
		rd(8'h20, 8'h00, "unmapped read");
		$display("test refused accesses done");
		i_input_dc_limit_enable = 1'b1;
		foreach (flag_bits[b]) begin
			pulse_faults(8'h01 << flag_bits[b]);
			rd(LCF_ADDR_FAULT, 8'h01 << flag_bits[b], "fault flag");
			rd(LCF_ADDR_FAULT, 8'h00, "fault flag after read");
		end
		v = 8'($random(seed)) & 8'hf3;
		pulse_faults(v);
		rd(LCF_ADDR_FAULT, v, "random fault mix");
		i_input_dc_limit_enable = 1'b0;
		pulse_faults(8'h01);
		rd(LCF_ADDR_FAULT, 8'h00, "dc limit disabled");
		set_faults(8'h04);
		i_lcf_host.tick(6);
		rd(LCF_ADDR_FAULT, 8'h00, "low battery disabled");
		i_low_battery_enable = 1'b1;
		i_lcf_host.tick(6);
		rd(LCF_ADDR_FAULT, 8'h04, "low battery below");
		set_faults(8'h00);
		i_lcf_host.tick(6);
		rd(LCF_ADDR_FAULT, 8'h00, "low battery above");
		{i_flash_active, i_transmit_mask_input} = 2'b11;
		i_lcf_host.tick(6);
		i_transmit_mask_input = 1'b0;
		i_lcf_host.tick(2);
		i_flash_active = 1'b0;
		i_lcf_host.tick(6);
		rd(LCF_ADDR_FAULT, 8'h08, "mask during flash");
		rd(LCF_ADDR_FAULT, 8'h08, "mask record held");
		i_flash_active = 1'b1;
		i_lcf_host.tick(6);
		rd(LCF_ADDR_FAULT, 8'h00, "flash without mask");
		i_flash_active = 1'b0;
		$display("test fault flags done");
		acc = 8'h00;
		repeat (24) begin
			r = $random(seed);
			set_faults(r[7:0]);
			{i_flash_active, i_transmit_mask_input} = r[9:8];
			{i_input_dc_limit_enable, i_low_battery_enable} = r[11:10];
			acc = acc | r[7:0];
			i_lcf_host.tick(8);
		end
		set_faults(8'h00);
		{i_flash_active, i_transmit_mask_input} = 2'b00;
		i_lcf_host.tick(6);
		i_lcf_host.read_reg(LCF_ADDR_FAULT, v);
		check("random soak faults", v & 8'hf6, acc & 8'hf2);
		check("sda data level", {7'h0, o_sda_out}, 8'h00);
		$display("test random soak done");
		give_verdict();
	end
endmodule
